//--- pkg/tap_pkg.sv
// Shared constants and types for the memory test access port
package tap_pkg;

   // ----------------------------------------
   // Register widths
   // ----------------------------------------
   localparam int IR_W  = 3;
   localparam int ID_W  = 32;
   localparam int BSR_W = 75;

   // ----------------------------------------
   // Instruction codes
   // ----------------------------------------
   localparam logic [IR_W-1:0] INS_SAMPLE_HIZ = 3'h0;
   localparam logic [IR_W-1:0] INS_IDENT      = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPLE_Z   = 3'h2;
   localparam logic [IR_W-1:0] INS_SAMPLE     = 3'h4;
   localparam logic [IR_W-1:0] INS_BYPASS     = 3'h7;

   // ----------------------------------------
   // Capture and reset values
   // ----------------------------------------
   localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;
   localparam logic [IR_W-1:0] IR_RESET_VAL   = INS_IDENT;
   localparam logic            BYPASS_CAP_VAL = 1'b0;
   localparam logic            TDO_RESET_VAL  = 1'b0;
   localparam logic            OE_RESET_VAL   = 1'b0;
   localparam logic            HIZ_RESET_VAL  = 1'b0;
   // Arbitrary identification value; bit 0 marks the register present
   localparam logic [ID_W-1:0] ID_VALUE       = 32'h5a3c_0001;
   localparam logic [BSR_W-1:0] BSR_RESET_VAL = '0;

   // ----------------------------------------
   // Pin synchroniser: bit order {tdi, tms, tck}
   // ----------------------------------------
   localparam int             PIN_W         = 3;
   localparam int             PIN_TCK       = 0;
   localparam int             PIN_TMS       = 1;
   localparam int             PIN_TDI       = 2;
   localparam logic [PIN_W-1:0] PIN_RESET_VAL = 3'h6;

   // Rising test clock edges with mode select high that force reset
   localparam int TMS_RESET_EDGES = 5;

   // ----------------------------------------
   // Controller states and data register select
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_RESET, ST_IDLE,
      ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } tap_state_type;

   typedef enum logic [1:0] {
      SEL_BYPASS, SEL_IDENT, SEL_BOUNDARY
   } dr_sel_type;

endpackage : tap_pkg

//--- pkg/tap_link_if.sv
// Synchronised test pin events and controller state
`timescale 1ns/1ps
interface tap_link_if;
   import tap_pkg::*;

   logic          tck_rise;
   logic          tck_fall;
   logic          tms;
   logic          tdi;
   tap_state_type state;

   modport sync (output tck_rise, output tck_fall, output tms, output tdi);
   modport fsm  (input tck_rise, input tms, output state);
   modport core (input tck_rise, input tck_fall, input tdi, input state);

endinterface : tap_link_if

//--- rtl/tap_pin_sync.sv
// Two-stage synchroniser for the test pins with test clock edge detect
`timescale 1ns/1ps
module tap_pin_sync (
   // Clock and reset
   input  wire logic                    i_sys_clk,
   input  wire logic                    i_rst,
   // Raw pins
   input  wire logic [tap_pkg::PIN_W-1:0] i_pins,
   // Synchronised events
   tap_link_if.sync                     lnk
);
   import tap_pkg::*;

   logic [PIN_W-1:0] meta_r;
   logic [PIN_W-1:0] sync_r;
   logic             tck_d_r;

   // ----------------------------------------
   // Synchroniser
   // ----------------------------------------
   // Undriven mode select and data read high, as a pull-up would give
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= PIN_RESET_VAL;
         sync_r <= PIN_RESET_VAL;
      end else begin
         meta_r <= i_pins;
         sync_r <= meta_r;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tck_d_r <= PIN_RESET_VAL[PIN_TCK];
      end else begin
         tck_d_r <= sync_r[PIN_TCK];
      end
   end

   assign lnk.tck_rise = sync_r[PIN_TCK] & ~tck_d_r;
   assign lnk.tck_fall = ~sync_r[PIN_TCK] & tck_d_r;
   assign lnk.tms      = sync_r[PIN_TMS];
   assign lnk.tdi      = sync_r[PIN_TDI];

endmodule : tap_pin_sync

//--- rtl/tap_ctrl_fsm.sv
// Sixteen-state test access port controller
`timescale 1ns/1ps
module tap_ctrl_fsm (
   // Clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst,
   // Events and state
   tap_link_if.fsm   lnk
);
   import tap_pkg::*;

   tap_state_type state_r;
   tap_state_type state_nxt;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Five high mode-select edges reach reset from any state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RESET:  state_nxt = lnk.tms ? ST_RESET  : ST_IDLE;
         ST_IDLE:   state_nxt = lnk.tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: state_nxt = lnk.tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_nxt = lnk.tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  state_nxt = lnk.tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_nxt = lnk.tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: state_nxt = lnk.tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: state_nxt = lnk.tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_nxt = lnk.tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: state_nxt = lnk.tms ? ST_RESET  : ST_CAP_IR;
         ST_CAP_IR: state_nxt = lnk.tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  state_nxt = lnk.tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_nxt = lnk.tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: state_nxt = lnk.tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: state_nxt = lnk.tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_nxt = lnk.tms ? ST_SEL_DR : ST_IDLE;
         default:   state_nxt = ST_RESET;
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= ST_RESET;
      end else if (lnk.tck_rise) begin
         state_r <= state_nxt;
      end
   end

   assign lnk.state = state_r;

endmodule : tap_ctrl_fsm

//--- rtl/tap_port.sv
// Serial test access port of the burst memory: controller, scan registers, serial output
//
// What this block does
// - Inputs sampled on test clock rise, serial output launched on its fall.
// - Mode select steers the controller, sampled each rising test clock edge.
// - Undriven mode select reads high.
// - Serial input enters the most significant bit of the selected register.
// - Undriven serial input reads high.
// - Serial output is the selected register's lsb, changing on falling edges.
// - Output driver enabled only in shift states, otherwise high impedance.
// - Mode select high for five rising edges forces the reset state.
// - Port reset at any time leaves memory operation undisturbed.
// - Power-up reset puts the controller in reset, output high impedance.
// - Test clock held low keeps the port in reset, harmless.
// - Exactly one register in the serial path, chosen by the instruction.
// - Three-bit instruction register, shifting only while in the path.
// - Instruction becomes identification at power-up and every reset entry.
// - Capture-instruction loads binary 01 into the two lowest bits.
// - A single-bit bypass register gives one stage of delay.
// - Bypass bit cleared to zero when the bypass instruction acts.
// - Identification selects a fixed 32-bit register, captured then shifted.
// - All-zero instruction samples the pin ring and floats memory outputs.
// - Sample-with-outputs-off shifts the boundary register, floats memory outputs.
// - Bypass instruction shifts the bypass register in shift-data.
`timescale 1ns/1ps
module tap_port (
   // Clock and reset
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_rst,

   // Test pins
   input  wire logic                      i_tck,
   input  wire logic                      i_tms,
   input  wire logic                      i_tdi,
   output logic                           o_tdo,
   output logic                           o_tdo_oe,

   // Memory pin ring and output control
   input  wire logic [tap_pkg::BSR_W-1:0] i_ring_pins,
   output logic                           o_mem_hiz
);
   import tap_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   tap_link_if lnk ();

   logic [IR_W-1:0]  ir_shift_r;
   logic [IR_W-1:0]  ir_shift_nxt;
   logic [IR_W-1:0]  ir_active_r;
   logic [IR_W-1:0]  ir_active_nxt;
   logic             bypass_r;
   logic             bypass_nxt;
   logic [ID_W-1:0]  id_r;
   logic [ID_W-1:0]  id_nxt;
   logic [BSR_W-1:0] bsr_r;
   logic [BSR_W-1:0] bsr_nxt;
   logic             tdo_r;
   logic             tdo_nxt;
   logic             tdo_oe_r;
   logic             tdo_oe_nxt;
   logic             mem_hiz_r;
   logic             mem_hiz_nxt;

   dr_sel_type       dr_sel;
   logic             in_cap_dr;
   logic             in_sh_dr;
   logic             in_cap_ir;
   logic             in_sh_ir;
   logic             in_exit_ir;
   logic             in_reset;
   logic             dr_lsb;
   logic             ir_cap_go;
   logic             ir_sh_go;
   logic             ir_upd_go;
   logic             dr_cap_go;
   logic             dr_sh_go;

   // ----------------------------------------
   // Pin synchroniser and controller
   // ----------------------------------------
   // Test clock is sampled, not used as a clock; it must stay well below
   // a quarter of the system clock rate for edges to be seen.
   tap_pin_sync u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_pins    ({i_tdi, i_tms, i_tck}),
      .lnk       (lnk.sync)
   );

   tap_ctrl_fsm u_fsm (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .lnk       (lnk.fsm)
   );

   // ----------------------------------------
   // State decode
   // ----------------------------------------
   assign in_reset  = (lnk.state == ST_RESET);
   assign in_cap_dr = (lnk.state == ST_CAP_DR);
   assign in_sh_dr  = (lnk.state == ST_SH_DR);
   assign in_cap_ir = (lnk.state == ST_CAP_IR);
   assign in_sh_ir  = (lnk.state == ST_SH_IR);
   assign in_exit_ir = (lnk.state == ST_EX1_IR) | (lnk.state == ST_EX2_IR);

   // ----------------------------------------
   // Test clock strobes
   // ----------------------------------------
   // One system clock wide, so each test clock edge acts exactly once
   assign ir_cap_go = lnk.tck_rise & in_cap_ir;
   assign ir_sh_go  = lnk.tck_rise & in_sh_ir;
   assign ir_upd_go = lnk.tck_rise & in_exit_ir & lnk.tms;
   assign dr_cap_go = lnk.tck_rise & in_cap_dr;
   assign dr_sh_go  = lnk.tck_rise & in_sh_dr;

   // ----------------------------------------
   // Instruction decode
   // ----------------------------------------
   // Reserved codes fall back to bypass so the chain length stays defined
   always_comb begin
      case (ir_active_r)
         INS_IDENT:      dr_sel = SEL_IDENT;
         INS_BYPASS:     dr_sel = SEL_BYPASS;
         INS_SAMPLE:     dr_sel = SEL_BOUNDARY;
         INS_SAMPLE_Z:   dr_sel = SEL_BOUNDARY;
         INS_SAMPLE_HIZ: dr_sel = SEL_BOUNDARY;
         default:        dr_sel = SEL_BYPASS;
      endcase
   end

   always_comb begin
      case (dr_sel)
         SEL_IDENT:    dr_lsb = id_r[0];
         SEL_BOUNDARY: dr_lsb = bsr_r[0];
         SEL_BYPASS:   dr_lsb = bypass_r;
         default:      dr_lsb = bypass_r;
      endcase
   end

   // ----------------------------------------
   // Instruction shift register
   // ----------------------------------------
   always_comb begin
      ir_shift_nxt = ir_shift_r;
      if (ir_cap_go) begin
         ir_shift_nxt = IR_CAPTURE_VAL;
      end else if (ir_sh_go) begin
         ir_shift_nxt = {lnk.tdi, ir_shift_r[IR_W-1:1]};
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ir_shift_r <= IR_RESET_VAL;
      end else begin
         ir_shift_r <= ir_shift_nxt;
      end
   end

   // ----------------------------------------
   // Active instruction
   // ----------------------------------------
   // Loaded on the edge that enters update, so the old code holds until then
   always_comb begin
      ir_active_nxt = ir_active_r;
      if (in_reset) begin
         ir_active_nxt = IR_RESET_VAL;
      end else if (ir_upd_go) begin
         ir_active_nxt = ir_shift_r;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ir_active_r <= IR_RESET_VAL;
      end else begin
         ir_active_r <= ir_active_nxt;
      end
   end

   // ----------------------------------------
   // Bypass register
   // ----------------------------------------
   always_comb begin
      bypass_nxt = bypass_r;
      if (dr_sel == SEL_BYPASS) begin
         if (dr_cap_go) begin
            bypass_nxt = BYPASS_CAP_VAL;
         end else if (dr_sh_go) begin
            bypass_nxt = lnk.tdi;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         bypass_r <= BYPASS_CAP_VAL;
      end else begin
         bypass_r <= bypass_nxt;
      end
   end

   // ----------------------------------------
   // Identification register
   // ----------------------------------------
   always_comb begin
      id_nxt = id_r;
      if (dr_sel == SEL_IDENT) begin
         if (dr_cap_go) begin
            id_nxt = ID_VALUE;
         end else if (dr_sh_go) begin
            id_nxt = {lnk.tdi, id_r[ID_W-1:1]};
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         id_r <= ID_VALUE;
      end else begin
         id_r <= id_nxt;
      end
   end

   // ----------------------------------------
   // Boundary register
   // ----------------------------------------
   // Capture only; there is no preload path back to the memory pins, so
   // update-data has no effect here.
   always_comb begin
      bsr_nxt = bsr_r;
      if (dr_sel == SEL_BOUNDARY) begin
         if (dr_cap_go) begin
            bsr_nxt = i_ring_pins;
         end else if (dr_sh_go) begin
            bsr_nxt = {lnk.tdi, bsr_r[BSR_W-1:1]};
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         bsr_r <= BSR_RESET_VAL;
      end else begin
         bsr_r <= bsr_nxt;
      end
   end

   // ----------------------------------------
   // Serial output
   // ----------------------------------------
   // Launched on the falling edge, half a test clock before the far end samples
   always_comb begin
      tdo_nxt = tdo_r;
      if (lnk.tck_fall) begin
         if (in_sh_ir) begin
            tdo_nxt = ir_shift_r[0];
         end else if (in_sh_dr) begin
            tdo_nxt = dr_lsb;
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tdo_r <= TDO_RESET_VAL;
      end else begin
         tdo_r <= tdo_nxt;
      end
   end

   // ----------------------------------------
   // Serial output enable
   // ----------------------------------------
   always_comb begin
      tdo_oe_nxt = tdo_oe_r;
      if (in_reset) begin
         tdo_oe_nxt = 1'b0;
      end else if (lnk.tck_fall) begin
         tdo_oe_nxt = in_sh_ir | in_sh_dr;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tdo_oe_r <= OE_RESET_VAL;
      end else begin
         tdo_oe_r <= tdo_oe_nxt;
      end
   end

   // ----------------------------------------
   // Memory output float
   // ----------------------------------------
   // Only the instruction steers this; reset restores the identification
   // code, which leaves the memory running untouched.
   always_comb begin
      case (ir_active_r)
         INS_SAMPLE_HIZ: mem_hiz_nxt = 1'b1;
         INS_SAMPLE_Z:   mem_hiz_nxt = 1'b1;
         default:        mem_hiz_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mem_hiz_r <= HIZ_RESET_VAL;
      end else begin
         mem_hiz_r <= mem_hiz_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_tdo     = tdo_r;
   assign o_tdo_oe  = tdo_oe_r;
   assign o_mem_hiz = mem_hiz_r;

endmodule : tap_port

//--- test/tap_port_asserts.sv
// Concurrent checks on the test access port pins
`timescale 1ns/1ps
module tap_port_asserts (
   // Clock and reset
   input wire logic                      i_sys_clk,
   input wire logic                      i_rst,
   // Test pins
   input wire logic                      i_tck,
   input wire logic                      i_tms,
   input wire logic                      i_tdi,
   input wire logic                      o_tdo,
   input wire logic                      o_tdo_oe,
   // Memory side
   input wire logic [tap_pkg::BSR_W-1:0] i_ring_pins,
   input wire logic                      o_mem_hiz
);
   import tap_pkg::*;
   localparam logic [2:0] RST_EDGES = 3'(TMS_RESET_EDGES);
   // -----
   // Helper: own count of test clock rises with mode select high
   // -----
   logic [2:0] tk_r;
   logic [1:0] ms_r;
   logic [2:0] cnt_r;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         tk_r <= 3'h0;
         ms_r <= 2'h3;
      end else begin
         tk_r <= {tk_r[1:0], i_tck};
         ms_r <= {ms_r[0], i_tms};
      end
   end
   // Saturates so a long reset run stays flagged
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_r <= RST_EDGES;
      end else if (tk_r[1] && !tk_r[2]) begin
         cnt_r <= !ms_r[1] ? 3'h0 : (cnt_r == RST_EDGES ? RST_EDGES : cnt_r + 3'h1);
      end
   end
   // -----
   // Assertions
   // -----
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   reset_quiet_a: assert property (disable iff (1'b0) i_rst |-> !o_tdo_oe && !o_mem_hiz)
      else $error("outputs active during reset");
   tdo_on_fall_a: assert property ($changed(o_tdo) |-> !$past(i_tck, 2))
      else $error("tdo moved outside a falling test clock");
   oe_on_fall_a: assert property ($rose(o_tdo_oe) |-> !$past(i_tck) && !$past(i_tck, 2))
      else $error("tdo driver enabled outside a falling test clock");
   oe_hold_a: assert property ($rose(o_tdo_oe) |-> o_tdo_oe [*6])
      else $error("tdo driver enable too short");
   tdo_with_oe_a: assert property ($changed(o_tdo) |-> o_tdo_oe)
      else $error("tdo moved with driver off");
   hiz_on_rise_a: assert property ($changed(o_mem_hiz) |-> $past(i_tck, 2))
      else $error("memory float changed off a rising test clock");
   tms_reset_a: assert property (cnt_r == RST_EDGES |-> ##[0:4] (!o_tdo_oe && !o_mem_hiz))
      else $error("five mode-select highs did not reset the port");
   tck_idle_a: assert property (!i_tck [*8] |-> $stable(o_tdo) && $stable(o_tdo_oe)
                                && $stable(o_mem_hiz))
      else $error("outputs moved with test clock idle");
   // -----
   // Covers
   // -----
   cover property ($rose(o_tdo_oe));
   cover property ($rose(o_mem_hiz));
   cover property (cnt_r == RST_EDGES - 3'h1 && ms_r[1]);
endmodule : tap_port_asserts

bind tap_port tap_port_asserts tap_port_asserts_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
   .i_ring_pins(i_ring_pins), .o_mem_hiz(o_mem_hiz));

//--- test/jtag_ctl_model.sv
// Behavioural boundary-scan controller on the far side of the port
`timescale 1ns/1ps
module jtag_ctl_model (
   // Test pins
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   import tap_pkg::*;
   // Clock stands still between frames; released pins float high
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   // One test clock; tdo read mid high phase, clear of its launch
   task automatic step(input logic ms, input logic di, output logic dq);
      o_tms = ms;
      o_tdi = di;
      #100 o_tck = 1'b1;
      #50 dq = i_tdo_oe ? i_tdo : 1'bz;
      #50 o_tck = 1'b0;
   endtask : step
   task automatic tap_reset();
      logic dq;
      repeat (5) step(1'b1, 1'b1, dq);
      step(1'b0, 1'b1, dq);
      o_tms = 1'b1;
      // Idle gap, so a following call never reassigns a pin in this step
      #50;
   endtask : tap_reset
   // Idle to shift, n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [BSR_W-1:0] din,
                       output logic [BSR_W-1:0] dout);
      logic dq;
      dout = '0;
      step(1'b0, 1'b1, dq);
      step(1'b1, 1'b1, dq);
      if (ir) step(1'b1, 1'b1, dq);
      step(1'b0, 1'b1, dq);
      step(1'b0, 1'b1, dq);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dq);
         dout[i] = dq;
      end
      step(1'b1, 1'b1, dq);
      step(1'b0, 1'b1, dq);
      o_tms = 1'b1;
      o_tdi = 1'b1;
      #50;
   endtask : scan
endmodule : jtag_ctl_model

//--- test/testbench.sv
// Self-checking bench for the memory test access port
`timescale 1ns/1ps
module testbench;
   import tap_pkg::*;
   // -----
   // Signals and instances
   // -----
   logic             clk, rst, tck, tms, tdi, tdo, tdo_oe, hiz;
   logic [BSR_W-1:0] ring;
   int               err_total = 0;
   int               n_checks = 0;
   int               cyc = 0;
   tap_port tap_port_inst (.i_sys_clk(clk), .i_rst(rst), .i_tck(tck), .i_tms(tms),
      .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_ring_pins(ring), .o_mem_hiz(hiz));
   jtag_ctl_model jtag_ctl_model_inst (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
      .i_tdo(tdo), .i_tdo_oe(tdo_oe));
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   // -----
   // Common tasks
   // -----
   task automatic check(input logic [BSR_W-1:0] seen, input logic [BSR_W-1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   // Float must not move before the update rise
   task automatic load(input logic [IR_W-1:0] code, input logic hiz_before);
      logic [BSR_W-1:0] d;
      fork
         jtag_ctl_model_inst.scan(1'b1, IR_W, BSR_W'(code), d);
         #1690 check(BSR_W'(hiz), BSR_W'(hiz_before));
      join
      check(d, BSR_W'(IR_CAPTURE_VAL));
   endtask : load
   task automatic read_id();
      logic [BSR_W-1:0] d;
      jtag_ctl_model_inst.scan(1'b0, ID_W, '0, d);
      check(d, BSR_W'(ID_VALUE));
   endtask : read_id
   // -----
   // Scenarios
   // -----
   task automatic t_power();
      repeat (40) @(negedge clk);
      check(BSR_W'({tdo_oe, hiz, tms, tdi}), BSR_W'(4'h3));
      read_id();
      $display("power-up done");
   endtask : t_power
   task automatic t_hiz();
      logic [IR_W-1:0] codes [5] = '{INS_SAMPLE_HIZ, INS_SAMPLE, INS_SAMPLE_Z,
                                     INS_BYPASS, INS_IDENT};
      logic [4:0]      fl = 5'h05;
      logic            prev = 1'b0;
      for (int i = 0; i < 5; i++) begin
         load(codes[i], prev);
         check(BSR_W'(hiz), BSR_W'(fl[i]));
         prev = fl[i];
      end
      load(INS_SAMPLE_HIZ, 1'b0);
      jtag_ctl_model_inst.tap_reset();
      check(BSR_W'({tdo_oe, hiz}), '0);
      read_id();
      $display("instruction decode done");
   endtask : t_hiz
   task automatic t_bypass();
      logic [IR_W-1:0]  codes [2] = '{INS_BYPASS, 3'h3};
      logic [BSR_W-1:0] d;
      foreach (codes[i]) begin
         load(codes[i], 1'b0);
         jtag_ctl_model_inst.scan(1'b0, 8, BSR_W'(8'hb5), d);
         check(d, BSR_W'(8'h6a));
      end
      $display("bypass done");
   endtask : t_bypass
   task automatic t_ring();
      logic [BSR_W-1:0] d;
      logic [BSR_W-1:0] pat = {11'h5a3, 64'hc3a5_0ff0_1234_8001};
      @(negedge clk) ring = pat;
      load(INS_SAMPLE_Z, 1'b0);
      check(BSR_W'(hiz), BSR_W'(1'b1));
      jtag_ctl_model_inst.scan(1'b0, BSR_W, ~pat, d);
      check(d, pat);
      $display("boundary capture done");
   endtask : t_ring
   // Second power-up reset in mid-run
   task automatic t_rst();
      @(negedge clk) rst = 1'b1;
      repeat (2) @(negedge clk);
      check(BSR_W'({tdo_oe, hiz}), '0);
      rst = 1'b0;
      read_id();
      $display("mid-run reset done");
   endtask : t_rst
   // -----
   // Main sequence and hang guard
   // -----
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         err_total++;
         end_of_test();
      end
   end
   initial begin
      rst = 1'b1;
      ring = '0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_power();
      t_hiz();
      t_bypass();
      t_ring();
      t_rst();
      end_of_test();
   end
endmodule : testbench
